// >>> hw/serial_led_stream.sv
// serial lamp stream: framed 24-bit and compact 16-bit lamp shifters,
// lamp test forcing, parallel lamp gating, apb register port with interrupt.
// assumes status inputs come from logic on i_clk; strap pins are asynchronous.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
module serial_led_stream
  import lamp_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [11:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  output logic                         o_irq,
  input  wire port_stat_t [PORTS-1:0]  i_port_stat,
  input  wire logic                    i_lamp_strap_n,
  input  wire logic                    i_compact_lamp_strap_n,
  input  wire logic                    i_autoneg_strap,
  output logic                         o_lamp_serial_out_n,
  output logic                         o_lamp_shift_clock,
  output logic                         o_lamp_frame_pulse,
  output logic      [PORTS-1:0]        o_link_lamp_n,
  output logic      [PORTS-1:0]        o_activity_lamp_n,
  output logic      [PORTS-1:0]        o_duplex_lamp_n,
  output logic      [PORTS-1:0]        o_speed_lamp_n,
  output logic      [PORTS-1:0]        o_receive_lamp_n,
  output logic      [PORTS-1:0]        o_autoneg_en
);

  function automatic option_t decode_option(input logic [15:0] v);
    if (v[OPT_FDX_BIT])
      return OPT_DUPLEX;
    else if (v[OPT_IRQ_BIT])
      return OPT_INTR;
    else
      return OPT_NORMAL;
  endfunction : decode_option

  // ---------------- strap capture ----------------
  logic [2:0] strap_m_q;
  logic [2:0] strap_s_q;
  logic [1:0] strap_cnt_q;
  logic       strap_done_q;
  logic       hw_serial_q;
  logic       compact_q;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
    end
    else
    begin
      strap_m_q <= {i_autoneg_strap, i_compact_lamp_strap_n, i_lamp_strap_n};
      strap_s_q <= strap_m_q;
    end
  end

  // lamp straps are caught once, after the synchroniser has filled post-release
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      hw_serial_q  <= 1'b0;
      compact_q    <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT)
      begin
        strap_done_q <= 1'b1;
        hw_serial_q  <= ~strap_s_q[0];
        compact_q    <= ~strap_s_q[1];
      end
    end
  end

  wire autoneg_pin = strap_s_q[2];

  // ---------------- register file ----------------
  logic [15:0] ctrl_q      [PORTS];
  logic [15:0] link_test_q [PORTS];
  logic [15:0] option_q    [PORTS];
  logic [15:0] lamp_cfg_q  [PORTS];
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;

  wire [8:0] idx       = i_paddr[10:2];
  wire [1:0] idx_port  = idx[6:5];
  wire [4:0] idx_reg   = idx[4:0];
  wire       phy_space = (idx[8:7] == 2'h0) && (i_paddr[11] == 1'b0);
  wire       hit_ctrl  = phy_space && (idx_reg == REG_CTRL);
  wire       hit_link  = phy_space && (idx_reg == REG_LINK_TEST);
  wire       hit_opt   = phy_space && (idx_reg == REG_OPTION);
  wire       hit_cfg   = phy_space && (idx_reg == REG_LAMP_CFG);
  wire       hit_stat  = (i_paddr[11] == 1'b0) && (idx == IDX_IRQ_STAT);
  wire       hit_mask  = (i_paddr[11] == 1'b0) && (idx == IDX_IRQ_MASK);
  wire       hit_mode  = (i_paddr[11] == 1'b0) && (idx == IDX_MODE);
  wire       mapped    = hit_ctrl | hit_link | hit_opt | hit_cfg | hit_stat | hit_mask | hit_mode;
  wire       setup     = i_psel && !i_penable;
  wire       access    = i_psel && i_penable && o_pready;
  wire       wr_ok     = access && i_pwrite && mapped;
  wire       rd_stat   = access && !i_pwrite && hit_stat;

  wire        sw_serial  = lamp_cfg_q[SER_EN_PORT][SER_EN_BIT];
  wire        serial_on  = hw_serial_q | sw_serial;
  wire [31:0] mode_word  = {27'h0, serial_on, sw_serial, hw_serial_q, compact_q, strap_done_q};

  wire [31:0] rd_data =
    hit_ctrl ? {16'h0, ctrl_q[idx_port]}      :
    hit_link ? {16'h0, link_test_q[idx_port]} :
    hit_opt  ? {16'h0, option_q[idx_port]}    :
    hit_cfg  ? {16'h0, lamp_cfg_q[idx_port]}  :
    hit_stat ? {30'h0, irq_stat_q}            :
    hit_mask ? {30'h0, irq_mask_q}            :
    hit_mode ? mode_word                      : 32'h0;

  // no wait state: answer is prepared in the setup cycle so prdata is a flop
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= setup;
      o_prdata  <= setup ? rd_data : 32'h0;
      o_pslverr <= setup && !mapped;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int p = 0; p < PORTS; p++)
      begin
        ctrl_q[p]      <= CTRL_RESET;
        link_test_q[p] <= 16'h0;
        option_q[p]    <= 16'h0;
        lamp_cfg_q[p]  <= 16'h0;
      end
      irq_mask_q <= 2'h0;
    end
    else if (wr_ok)
    begin
      if (hit_ctrl)
        ctrl_q[idx_port] <= i_pwdata[15:0];
      if (hit_link)
        link_test_q[idx_port] <= i_pwdata[15:0];
      if (hit_opt)
        option_q[idx_port] <= i_pwdata[15:0];
      if (hit_cfg)
        lamp_cfg_q[idx_port] <= i_pwdata[15:0];
      if (hit_mask)
        irq_mask_q <= i_pwdata[1:0];
    end
  end

  // ---------------- effective lamp states ----------------
  logic [PORTS-1:0] eff_link;
  logic [PORTS-1:0] eff_act;
  logic [PORTS-1:0] eff_fdx;
  logic [PORTS-1:0] eff_spd;
  logic [PORTS-1:0] eff_col;
  logic [PORTS-1:0] eff_tx;
  logic [PORTS-1:0] eff_rx;
  logic [PORTS-1:0] slice_irq;
  logic [PORTS-1:0] an_en;

  // forcing only takes effect with the autoneg strap high
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      eff_link[p]  = i_port_stat[p].link |
                     (autoneg_pin && link_test_q[p] == FORCE_LINK_VAL);
      eff_act[p]   = i_port_stat[p].transmit | i_port_stat[p].receive |
                     (autoneg_pin && lamp_cfg_q[p] == FORCE_ACT_VAL);
      eff_fdx[p]   = i_port_stat[p].full_duplex_flag |
                     (autoneg_pin && lamp_cfg_q[p] == FORCE_ACT_VAL);
      eff_spd[p]   = i_port_stat[p].fast_speed_flag |
                     (autoneg_pin && ctrl_q[p] == FORCE_SPEED_VAL);
      eff_col[p]   = i_port_stat[p].collision;
      eff_tx[p]    = i_port_stat[p].transmit;
      eff_rx[p]    = i_port_stat[p].receive;
      slice_irq[p] = i_port_stat[p].intr;
      an_en[p]     = ctrl_q[p][CTRL_AUTONEG];
    end
  end

  wire global_irq = |slice_irq;

  // group bit order: element 0 is serial bit 0 (sent first)
  logic [FRAME_BITS-1:0] frame_word;
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      case (decode_option(option_q[p]))
        OPT_INTR:
          frame_word[p*6 +: 6] = {eff_fdx[p], global_irq, 1'b0, eff_link[p], slice_irq[p], eff_act[p]};
        OPT_DUPLEX:
          frame_word[p*6 +: 6] = {eff_fdx[p], eff_col[p], eff_spd[p], eff_link[p], eff_fdx[p], eff_act[p]};
        default:
          frame_word[p*6 +: 6] = {eff_fdx[p], eff_col[p], eff_spd[p], eff_link[p], eff_tx[p], eff_rx[p]};
      endcase
    end
  end

  // element 0 goes out first: activity 1..4, link, duplex, speed
  wire [COMPACT_BITS-1:0] compact_word = {eff_spd, eff_fdx, eff_link, eff_act};

  // ---------------- shift clock divider ----------------
  logic [DIV_W-1:0] div_q;
  logic             sclk_q;
  wire              half_end  = (div_q == HALF_LAST);
  wire              fall_tick = half_end && sclk_q;
  wire              run       = serial_on | compact_q;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end
    else if (!run)
    begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end
    else
    begin
      div_q <= half_end ? '0 : div_q + DIV_W'(1);
      if (half_end)
        sclk_q <= ~sclk_q;
    end
  end

  // ---------------- framed and compact shifters ----------------
  logic [4:0]            fbit_q;
  logic [FRAME_BITS-1:0] fsnap_q;
  logic [4:0]            cbit_q;
  logic [COMPACT_BITS-1:0] csnap_q;
  wire                   frame_wrap   = fall_tick && (fbit_q == FRAME_LAST);
  wire                   compact_wrap = fall_tick && (cbit_q == COMPACT_LAST);

  // bit counters step on falling shift clock edges; snapshot taken at bit 0
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fbit_q  <= 5'h0;
      fsnap_q <= '0;
      cbit_q  <= 5'h0;
      csnap_q <= '0;
    end
    else if (!run)
    begin
      fbit_q <= 5'h0;
      cbit_q <= 5'h0;
      fsnap_q <= frame_word;
      csnap_q <= compact_word;
    end
    else if (fall_tick)
    begin
      fbit_q <= frame_wrap ? 5'h0 : fbit_q + 5'h1;
      cbit_q <= compact_wrap ? 5'h0 : cbit_q + 5'h1;
      if (frame_wrap)
        fsnap_q <= frame_word;
      if (compact_wrap)
        csnap_q <= compact_word;
    end
  end

  // ---------------- pin outputs ----------------
  logic par_en;
  always_comb
  begin
    if (!serial_on)
      par_en = 1'b1;
    else
      par_en = (hw_serial_q && !sw_serial) || lamp_cfg_q[PAR_EN_PORT][SER_EN_BIT];
  end

  wire             ser_active = serial_on && run;
  wire             cmp_data   = csnap_q[cbit_q[3:0]];
  wire [PORTS-1:0] rx_lamp_n  = par_en ? ~eff_rx : {PORTS{1'b1}};

  // compact mode borrows receive lamp bits 0 and 2 as clock and data
  wire [PORTS-1:0] rx_pins = compact_q ?
    {rx_lamp_n[3], ~cmp_data, rx_lamp_n[1], sclk_q} : rx_lamp_n;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_lamp_serial_out_n <= 1'b1;
      o_lamp_shift_clock  <= 1'b0;
      o_lamp_frame_pulse  <= 1'b0;
      o_link_lamp_n       <= {PORTS{1'b1}};
      o_activity_lamp_n   <= {PORTS{1'b1}};
      o_duplex_lamp_n     <= {PORTS{1'b1}};
      o_speed_lamp_n      <= {PORTS{1'b1}};
      o_receive_lamp_n    <= {PORTS{1'b1}};
      o_autoneg_en        <= {PORTS{1'b1}};
    end
    else
    begin
      o_lamp_serial_out_n <= ser_active ? ~fsnap_q[fbit_q] : 1'b1;
      o_lamp_shift_clock  <= ser_active && sclk_q;
      o_lamp_frame_pulse  <= ser_active && (fbit_q == 5'h0);
      o_link_lamp_n       <= par_en ? ~eff_link : {PORTS{1'b1}};
      o_activity_lamp_n   <= par_en ? ~eff_act  : {PORTS{1'b1}};
      o_duplex_lamp_n     <= par_en ? ~eff_fdx  : {PORTS{1'b1}};
      o_speed_lamp_n      <= par_en ? ~eff_spd  : {PORTS{1'b1}};
      o_receive_lamp_n    <= rx_pins;
      o_autoneg_en        <= an_en;
    end
  end

  // ---------------- interrupt ----------------
  wire [1:0] irq_evt;
  assign irq_evt[IRQ_FRAME]   = frame_wrap && serial_on;
  assign irq_evt[IRQ_COMPACT] = compact_wrap && compact_q;

  // a new event in the clearing read's cycle survives the clear
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_stat_q <= 2'h0;
      o_irq      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | irq_evt;
      o_irq      <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : serial_led_stream
`default_nettype wire

// >>> common/lamp_pkg.sv
// constants and types shared by the serial lamp stream block
// assumes a 200 MHz system clock and a 32-bit apb register port
`default_nettype none
package lamp_pkg;
  localparam int unsigned SYS_CLK_HZ   = 200_000_000;
  localparam int unsigned SHIFT_CLK_HZ = 1_000_000;
  localparam int unsigned HALF_CYCLES  = SYS_CLK_HZ / (2 * SHIFT_CLK_HZ);
  localparam int unsigned DIV_W        = 8;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYCLES - 1);

  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned COMPACT_BITS = 16;
  localparam int unsigned PORTS        = 4;
  localparam logic [4:0] FRAME_LAST    = 5'h17;
  localparam logic [4:0] COMPACT_LAST  = 5'h0f;
  localparam logic [1:0] STRAP_WAIT    = 2'h3;

  // register indices; byte address is four times the index
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_LINK_TEST = 5'h18;
  localparam logic [4:0] REG_OPTION    = 5'h1a;
  localparam logic [4:0] REG_LAMP_CFG  = 5'h1b;
  localparam logic [8:0] IDX_IRQ_STAT  = 9'h080;
  localparam logic [8:0] IDX_IRQ_MASK  = 9'h081;
  localparam logic [8:0] IDX_MODE      = 9'h082;

  localparam logic [15:0] CTRL_RESET      = 16'h1000;
  localparam int unsigned CTRL_AUTONEG    = 12;
  localparam logic [15:0] FORCE_LINK_VAL  = 16'h403c;
  localparam logic [15:0] FORCE_ACT_VAL   = 16'h00aa;
  localparam logic [15:0] FORCE_SPEED_VAL = 16'h2000;
  localparam int unsigned OPT_IRQ_BIT     = 14;
  localparam int unsigned OPT_FDX_BIT     = 15;
  localparam int unsigned SER_EN_BIT      = 4;
  localparam logic [1:0]  SER_EN_PORT     = 2'h1;
  localparam logic [1:0]  PAR_EN_PORT     = 2'h2;

  localparam int unsigned IRQ_FRAME   = 0;
  localparam int unsigned IRQ_COMPACT = 1;

  typedef enum logic [1:0] {OPT_NORMAL, OPT_INTR, OPT_DUPLEX} option_t;

  typedef struct packed {
    logic link;
    logic fast_speed_flag;
    logic full_duplex_flag;
    logic collision;
    logic transmit;
    logic receive;
    logic intr;
  } port_stat_t;
endpackage : lamp_pkg
`default_nettype wire

// >>> bench/lamp_chain_model.sv
// external lamp shift-register chain: samples data on each shift clock rise
// assumes clock and data come from registered device outputs on i_clk
`default_nettype none
module lamp_chain_model
  import lamp_pkg::*;
#(
  parameter int unsigned BITS = FRAME_BITS
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sck,
  input  wire logic        i_sdo_n,
  input  wire logic        i_sync,
  output logic      [23:0] o_word,
  output int               o_frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sck_q;
  logic [4:0]  idx_q;
  logic [23:0] acc_q;
  wire         rise = i_sck & ~sck_q;
  wire  [4:0]  idx  = i_sync ? 5'h00 : idx_q;
  wire         last = (idx == 5'(BITS - 1));
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // starts high so a clock pin idling high at release is not taken as a rise
      sck_q    <= 1'b1;
      idx_q    <= 5'h00;
      acc_q    <= 24'h00_0000;
      o_word   <= 24'h00_0000;
      o_frames <= 0;
    end
    else
    begin
      sck_q <= i_sck;
      if (rise)
      begin
        // bits arrive first-at-bit-zero; shifting right lands them in place
        acc_q <= {~i_sdo_n, acc_q[23:1]};
        idx_q <= last ? 5'h00 : idx + 5'h01;
        if (last)
        begin
          o_word   <= {~i_sdo_n, acc_q[23:1]} >> (24 - BITS);
          o_frames <= o_frames + 1;
        end
      end
    end
  end
endmodule : lamp_chain_model
`default_nettype wire

// >>> bench/serial_led_stream_asserts.sv
// checker: lamp stream timing and apb answer relations
// assumes binding onto the serial_led_stream ports, 200 MHz clock
`default_nettype none
module serial_led_stream_asserts
  import lamp_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_pwrite,
  input wire logic [11:0]      i_paddr,
  input wire logic [31:0]      i_pwdata,
  input wire logic [31:0]      o_prdata,
  input wire logic             o_pready,
  input wire logic             o_pslverr,
  input wire logic             o_lamp_serial_out_n,
  input wire logic             o_lamp_shift_clock,
  input wire logic             o_lamp_frame_pulse,
  input wire logic [PORTS-1:0] o_autoneg_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  hi_q;
  logic [7:0]  pw_q;
  logic [12:0] gap_q;
  logic        seen_q;
  // counters saturate so a stuck clock never wraps into a false match
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hi_q   <= 8'h00;
      pw_q   <= 8'h00;
      gap_q  <= 13'h0000;
      seen_q <= 1'b0;
    end
    else
    begin
      hi_q   <= o_lamp_shift_clock ? hi_q + 8'(hi_q != 8'hff) : 8'h00;
      pw_q   <= o_lamp_frame_pulse ? pw_q + 8'(pw_q != 8'hff) : 8'h00;
      gap_q  <= $rose(o_lamp_frame_pulse) ? 13'h0001 : gap_q + 13'(gap_q != 13'h1fff);
      seen_q <= seen_q | $rose(o_lamp_frame_pulse);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_data_holds_high: assert property (o_lamp_shift_clock && $past(o_lamp_shift_clock) |-> $stable(o_lamp_serial_out_n))
    else $error("serial data moved while shift clock high");
  a_clock_high_len: assert property ($fell(o_lamp_shift_clock) |-> hi_q == 8'h64)
    else $error("shift clock high phase not 100 cycles");
  a_pulse_bit_len: assert property ($fell(o_lamp_frame_pulse) |-> pw_q == 8'hc8)
    else $error("frame pulse not one bit time long");
  a_pulse_frame_gap: assert property ($rose(o_lamp_frame_pulse) && seen_q |-> gap_q == 13'h12c0)
    else $error("frames not 24 bits back to back");
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  a_err_unmapped: assert property (i_psel && !i_penable && i_paddr == 12'h070 |=> o_pslverr)
    else $error("unmapped address not refused");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_autoneg_drop: assert property (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 12'h000
    && i_pwdata == 32'h0000_2000 |-> ##[1:2] !o_autoneg_en[0])
    else $error("speed test write kept autoneg on");
  c_frame: cover property ($rose(o_lamp_frame_pulse) && seen_q);
  c_refused: cover property (o_pslverr);
  c_autoneg: cover property ($fell(o_autoneg_en[0]));
endmodule : serial_led_stream_asserts
bind serial_led_stream serial_led_stream_asserts chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_lamp_serial_out_n, .o_lamp_shift_clock,
  .o_lamp_frame_pulse, .o_autoneg_en);
`default_nettype wire

// >>> bench/serial_led_stream_tb.sv
// testbench: apb master, status stimulus, two lamp chain models
// assumes 200 MHz clock; straps held from reset onward
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module serial_led_stream_tb
  import lamp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  port_stat_t [PORTS-1:0] stat;
  logic                   strap_n, cstrap_n, an_strap, sdo_n, sck, fp;
  logic [PORTS-1:0]       lnk_n, act_n, dup_n, spd_n, rcv_n, an_en;
  logic [23:0]            fword, cword;
  int                     fcnt, ccnt, err_count, checks_done, cyc;

  serial_led_stream dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
    .i_port_stat(stat), .i_lamp_strap_n(strap_n), .i_compact_lamp_strap_n(cstrap_n), .i_autoneg_strap(an_strap),
    .o_lamp_serial_out_n(sdo_n), .o_lamp_shift_clock(sck), .o_lamp_frame_pulse(fp), .o_link_lamp_n(lnk_n),
    .o_activity_lamp_n(act_n), .o_duplex_lamp_n(dup_n), .o_speed_lamp_n(spd_n), .o_receive_lamp_n(rcv_n),
    .o_autoneg_en(an_en));
  lamp_chain_model #(.BITS(FRAME_BITS)) chain (.i_clk(clk), .i_rst(rst), .i_sck(sck), .i_sdo_n(sdo_n),
    .i_sync(fp), .o_word(fword), .o_frames(fcnt));
  lamp_chain_model #(.BITS(COMPACT_BITS)) compact (.i_clk(clk), .i_rst(rst), .i_sck(rcv_n[0]),
    .i_sdo_n(rcv_n[2]), .i_sync(1'b0), .o_word(cword), .o_frames(ccnt));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // slow paths of a hang all end here
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge; answer taken there
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic sn, input logic cn);
    strap_n  <= sn;
    cstrap_n <= cn;
    rst      <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : do_reset

  task automatic wait_fr(input bit cmp, input int n);
    int s;
    s = cmp ? ccnt : fcnt;
    while ((cmp ? ccnt : fcnt) < s + n) @(posedge clk);
  endtask : wait_fr

  function automatic logic [3:0] links();
    logic [3:0] l;
    for (int p = 0; p < PORTS; p++) l[p] = stat[p].link;
    return l;
  endfunction : links

  function automatic logic [23:0] exp_frame(input logic [1:0] opt, input logic frc);
    logic [23:0] w;
    port_stat_t  s;
    logic        g, lk, ac;
    g = 1'b0;
    for (int p = 0; p < PORTS; p++) g = g | stat[p].intr;
    for (int p = 0; p < PORTS; p++)
    begin
      s  = stat[p];
      lk = s.link | frc;
      ac = s.transmit | s.receive;
      if (opt == 2'h0)
        w[6*p +: 6] = {s.full_duplex_flag, s.collision, s.fast_speed_flag, lk, s.transmit, s.receive};
      else if (opt == 2'h1)
        w[6*p +: 6] = {s.full_duplex_flag, g, 1'b0, lk, s.intr, ac};
      else
        w[6*p +: 6] = {s.full_duplex_flag, s.collision, s.fast_speed_flag, lk, s.full_duplex_flag, ac};
    end
    return w;
  endfunction : exp_frame

  function automatic logic [15:0] exp_compact();
    logic [15:0] w;
    for (int p = 0; p < PORTS; p++)
    begin
      w[p]      = stat[p].transmit | stat[p].receive;
      w[p + 4]  = stat[p].link;
      w[p + 8]  = stat[p].full_duplex_flag;
      w[p + 12] = stat[p].fast_speed_flag;
    end
    return w;
  endfunction : exp_compact

  task automatic t_defaults_force();
    do_reset(1'b1, 1'b1);
    apb(1'b0, 12'h208, 32'h0000_0000);
    `CHK("mode", 32'h0000_0001, rd)
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_1000, rd)
    apb(1'b0, 12'h070, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    for (int p = 0; p < PORTS; p++) apb(1'b1, 12'(p * 128) + 12'h060, 32'h0000_403c);
    apb(1'b1, 12'h06c, 32'h0000_00aa);
    apb(1'b1, 12'h000, 32'h0000_2000);
    repeat (3) @(posedge clk);
    `CHK("link force", 4'h0, lnk_n)
    `CHK("act dup force", 2'h0, {act_n[0], dup_n[0]})
    `CHK("speed autoneg", 2'h0, {spd_n[0], an_en[0]})
  endtask : t_defaults_force

  task automatic t_software();
    do_reset(1'b1, 1'b1);
    apb(1'b1, 12'h0ec, 32'h0000_0010);
    repeat (3) @(posedge clk);
    `CHK("par off", 20'hf_ffff, {lnk_n, act_n, dup_n, spd_n, rcv_n})
    apb(1'b0, 12'h208, 32'h0000_0000);
    `CHK("mode sw", 32'h0000_0019, rd)
    wait_fr(1'b0, 2);
    `CHK("normal", exp_frame(2'h0, 1'b0), fword)
    apb(1'b1, 12'h204, 32'h0000_0001);
    wait_fr(1'b0, 1);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, 12'h200, 32'h0000_0000);
    `CHK("irq stat", 1'b1, rd[0])
    repeat (3) @(posedge clk);
    `CHK("irq clr", 1'b0, irq)
    wait_fr(1'b0, 1);
    repeat (110) @(posedge clk);
    `CHK("irq event", 1'b1, irq)
    // the mapping option lives in each port's own register
    for (int p = 0; p < PORTS; p++) apb(1'b1, 12'(p * 128) + 12'h068, 32'h0000_4000);
    wait_fr(1'b0, 2);
    `CHK("intr map", exp_frame(2'h1, 1'b0), fword)
    for (int p = 0; p < PORTS; p++) apb(1'b1, 12'(p * 128) + 12'h068, 32'h0000_8000);
    wait_fr(1'b0, 2);
    `CHK("fdx map", exp_frame(2'h2, 1'b0), fword)
    apb(1'b1, 12'h16c, 32'h0000_0010);
    repeat (3) @(posedge clk);
    `CHK("par on", ~links(), lnk_n)
    for (int p = 0; p < PORTS; p++) apb(1'b1, 12'(p * 128) + 12'h060, 32'h0000_403c);
    wait_fr(1'b0, 2);
    `CHK("serial force", exp_frame(2'h2, 1'b1), fword)
  endtask : t_software

  task automatic t_strap_modes();
    do_reset(1'b0, 1'b1);
    `CHK("par hw", ~links(), lnk_n)
    wait_fr(1'b0, 2);
    `CHK("hw frame", exp_frame(2'h0, 1'b0), fword)
    do_reset(1'b1, 1'b0);
    wait_fr(1'b1, 2);
    `CHK("compact", exp_compact(), cword[15:0])
    `CHK("framed idle", 1'b0, sck)
  endtask : t_strap_modes

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    stat[0]     = 7'h44;
    stat[1]     = 7'h35;
    stat[2]     = 7'h62;
    stat[3]     = 7'h18;
    an_strap    = 1'b1;
    rst         = 1'b1;
    strap_n     = 1'b1;
    cstrap_n    = 1'b1;
    err_count   = 0;
    checks_done = 0;
    cyc         = 0;
    t_defaults_force();
    t_software();
    t_strap_modes();
    end_of_test();
  end
endmodule : serial_led_stream_tb
`default_nettype wire
